// File: hdl/ang_core.sv
// Angle sensor digital core: sampling, angle math, filter, direction flag, serial slave
`timescale 1ns/1ps
`include "ang_cfg.svh"
module ang_core #(
    parameter int unsigned SAMPLE_CYC = `ANG_SAMPLE_CYC,
    parameter int unsigned STORE_CYC = `ANG_STORE_CYC,
    // Lot code value is arbitrary
    parameter logic [47:0] LOT_CODE = 48'h3030_3030_3030
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Converter
    input wire logic [11:0] adc_sin_i,
    input wire logic [11:0] adc_cos_i,
    output logic adc_start_o,
    // Serial link
    input wire logic sclk_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Status
    output logic [11:0] angle_o,
    output logic dir_flag_o,
    output logic store_busy_o
);

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    function automatic logic [11:0] wrap_tenths(input logic signed [13:0] v);
        logic signed [13:0] w;
        w = v;
        if (v < 14'sh0000) begin
            w = v + `ANG_FULL_TENTHS;
        end else if (v >= `ANG_FULL_TENTHS) begin
            w = v - `ANG_FULL_TENTHS;
        end
        wrap_tenths = w[11:0];
    endfunction

    function automatic logic signed [17:0] atan_lut(input logic [3:0] i);
        case (i)
            4'h0: atan_lut = 18'sh01C20;
            4'h1: atan_lut = 18'sh0109A;
            4'h2: atan_lut = 18'sh008C6;
            4'h3: atan_lut = 18'sh00474;
            4'h4: atan_lut = 18'sh0023C;
            4'h5: atan_lut = 18'sh0011E;
            4'h6: atan_lut = 18'sh0008F;
            4'h7: atan_lut = 18'sh00048;
            4'h8: atan_lut = 18'sh00024;
            4'h9: atan_lut = 18'sh00012;
            4'hA: atan_lut = 18'sh00009;
            default: atan_lut = 18'sh00004;
        endcase
    endfunction

    // ---------------------------------------------
    // Sample timing
    // ---------------------------------------------
    logic [31:0] smp_cnt_ff;
    logic tick_ff;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            smp_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (ce_i) begin
            tick_ff <= (smp_cnt_ff == SAMPLE_CYC - 1);
            if (smp_cnt_ff == SAMPLE_CYC - 1) begin
                smp_cnt_ff <= 32'h0000_0000;
            end else begin
                smp_cnt_ff <= smp_cnt_ff + 32'h0000_0001;
            end
        end
    end
    assign adc_start_o = tick_ff;

    AST_TICK: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        tick_ff |=> !tick_ff [*8])
        else $error("sample strobe repeats too soon");

    // ---------------------------------------------
    // Parameters and stores
    // ---------------------------------------------
    logic rot_ff;
    logic [13:0] offset_ff;
    logic [7:0] filt_m_ff;
    logic [7:0] hyst_ff;
    logic [31:0] store_cnt_ff;
    logic wr_go;
    logic [15:0] wr_data;
    logic [7:0] addr_ff;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rot_ff <= `ANG_ROT_RST;
            offset_ff <= `ANG_OFFSET_RST;
            filt_m_ff <= `ANG_FILTER_RST;
            hyst_ff <= `ANG_HYST_RST;
        end else if (ce_i && wr_go) begin
            // Out-of-range values and read-only addresses leave state untouched
            case (addr_ff)
                `ANG_ADR_ROT: begin
                    if (wr_data[15:1] == 15'h0000) begin
                        rot_ff <= wr_data[0];
                    end
                end
                `ANG_ADR_OFFSET: begin
                    if ({2'b00, wr_data} <= 18'(`ANG_FULL_TENTHS)) begin
                        offset_ff <= wr_data[`ANG_OFFSET_MSB:0];
                    end
                end
                `ANG_ADR_FILTER: begin
                    if (wr_data[15:8] == 8'h00 && wr_data[7:0] != 8'h00) begin
                        filt_m_ff <= wr_data[7:0];
                    end
                end
                `ANG_ADR_HYST: begin
                    if (wr_data[15:8] == 8'h00) begin
                        hyst_ff <= wr_data[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Store busy models the slow nonvolatile write; the master must wait it out
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            store_cnt_ff <= 32'h0000_0000;
            store_busy_o <= 1'b0;
        end else if (ce_i) begin
            if (wr_go) begin
                store_cnt_ff <= STORE_CYC;
                store_busy_o <= 1'b1;
            end else if (store_cnt_ff != 32'h0000_0000) begin
                store_cnt_ff <= store_cnt_ff - 32'h0000_0001;
                store_busy_o <= (store_cnt_ff != 32'h0000_0001);
            end
        end
    end

    // ---------------------------------------------
    // Angle engine
    // ---------------------------------------------
    ang_pkg::ang_state_t state_ff;
    logic [3:0] it_ff;
    logic signed [14:0] x_ff;
    logic signed [14:0] y_ff;
    logic signed [17:0] z_ff;
    logic [11:0] sin_ff;
    logic [11:0] cos_ff;
    logic [11:0] meas_ff;
    logic [11:0] angle_ff;
    logic [11:0] dref_ff;
    logic dir_ff;
    logic signed [14:0] cx;
    logic signed [14:0] sy;
    logic signed [17:0] zw;
    logic [11:0] raw_t;
    logic [11:0] dir_t;
    logic [19:0] prod;
    logic [11:0] filt_new;
    logic signed [13:0] delta;
    logic signed [13:0] hyst_s;

    assign cx = $signed({3'b000, adc_cos_i}) - `ANG_ADC_MID;
    assign sy = $signed({3'b000, adc_sin_i}) - `ANG_ADC_MID;

    always_comb begin
        zw = (z_ff < 18'sh00000) ? z_ff + `ANG_FULL_FINE : z_ff;
        raw_t = wrap_tenths(14'((zw + `ANG_FINE_ROUND) >>> `ANG_FINE_SHIFT));
        if (rot_ff) begin
            dir_t = wrap_tenths(`ANG_FULL_TENTHS - $signed({2'b00, raw_t}));
        end else begin
            dir_t = raw_t;
        end
        prod = 20'(meas_ff) + 20'(filt_m_ff - 8'h01) * 20'(angle_ff);
        // Linear average: a step across the wrap point is smoothed the long way
        if (filt_m_ff <= 8'h01) begin
            filt_new = meas_ff;
        end else begin
            filt_new = 12'(prod / 20'(filt_m_ff));
        end
        delta = $signed({2'b00, filt_new}) - $signed({2'b00, dref_ff});
        if (delta > `ANG_HALF_TENTHS) begin
            delta = delta - `ANG_FULL_TENTHS;
        end else if (delta < -`ANG_HALF_TENTHS) begin
            delta = delta + `ANG_FULL_TENTHS;
        end
        hyst_s = $signed({6'h00, hyst_ff});
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff <= ang_pkg::ANG_IDLE;
            it_ff <= 4'h0;
            x_ff <= 15'sh0000;
            y_ff <= 15'sh0000;
            z_ff <= 18'sh00000;
            sin_ff <= 12'h000;
            cos_ff <= 12'h000;
            meas_ff <= 12'h000;
        end else if (ce_i) begin
            case (state_ff)
                ang_pkg::ANG_IDLE: begin
                    if (tick_ff) begin
                        sin_ff <= adc_sin_i;
                        cos_ff <= adc_cos_i;
                        it_ff <= 4'h0;
                        // Fold the left half plane so the rotations converge
                        if (cx < 15'sh0000) begin
                            x_ff <= -cx;
                            y_ff <= -sy;
                            z_ff <= `ANG_HALF_FINE;
                        end else begin
                            x_ff <= cx;
                            y_ff <= sy;
                            z_ff <= 18'sh00000;
                        end
                        state_ff <= ang_pkg::ANG_ROT;
                    end
                end
                ang_pkg::ANG_ROT: begin
                    if (y_ff > 15'sh0000) begin
                        x_ff <= x_ff + (y_ff >>> it_ff);
                        y_ff <= y_ff - (x_ff >>> it_ff);
                        z_ff <= z_ff + atan_lut(it_ff);
                    end else begin
                        x_ff <= x_ff - (y_ff >>> it_ff);
                        y_ff <= y_ff + (x_ff >>> it_ff);
                        z_ff <= z_ff - atan_lut(it_ff);
                    end
                    it_ff <= it_ff + 4'h1;
                    if (it_ff == `ANG_ITER_LAST) begin
                        state_ff <= ang_pkg::ANG_MAP;
                    end
                end
                ang_pkg::ANG_MAP: begin
                    meas_ff <= wrap_tenths($signed({2'b00, dir_t}) - $signed(offset_ff));
                    state_ff <= ang_pkg::ANG_FILT;
                end
                default: begin
                    state_ff <= ang_pkg::ANG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            angle_ff <= 12'h000;
            dref_ff <= 12'h000;
            dir_ff <= 1'b0;
        end else if (ce_i && state_ff == ang_pkg::ANG_FILT) begin
            angle_ff <= filt_new;
            if (delta > hyst_s) begin
                dir_ff <= 1'b1;
                dref_ff <= filt_new;
            end else if (delta < -hyst_s) begin
                dir_ff <= 1'b0;
                dref_ff <= filt_new;
            end
        end
    end
    assign angle_o = angle_ff;
    assign dir_flag_o = dir_ff;

    AST_ENGINE_LEN: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        (state_ff == ang_pkg::ANG_IDLE && tick_ff) |=> (state_ff == ang_pkg::ANG_ROT) [*8]
        ##1 (state_ff == ang_pkg::ANG_ROT) [*4]
        ##1 (state_ff == ang_pkg::ANG_MAP) ##1 (state_ff == ang_pkg::ANG_FILT))
        else $error("angle engine did not take twelve rotation steps");
    AST_BYPASS: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        (state_ff == ang_pkg::ANG_FILT && filt_m_ff == 8'h01) |=> angle_ff == $past(meas_ff))
        else $error("weight one did not pass the sample through");
    AST_FILTER_BETWEEN: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        (state_ff == ang_pkg::ANG_FILT) |=>
        ((angle_ff >= $past(angle_ff) && angle_ff <= $past(meas_ff)) ||
         (angle_ff <= $past(angle_ff) && angle_ff >= $past(meas_ff))))
        else $error("filtered angle outside old and new values");
    AST_ANGLE_RANGE: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        {2'b00, angle_ff} < 14'(`ANG_FULL_TENTHS))
        else $error("angle out of range");
    AST_DIR_UP: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        (state_ff == ang_pkg::ANG_FILT && delta > hyst_s) |=> dir_ff && dref_ff == $past(filt_new))
        else $error("direction flag missed a rise beyond hysteresis");

    // ---------------------------------------------
    // Serial link: pin synchronisers
    // ---------------------------------------------
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] pin_ff;
    logic [2:0] pin_prev_ff;

    // A pin change counts only once the second and third stage agree
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_ff <= `ANG_SYNC_RST;
            s2_ff <= `ANG_SYNC_RST;
            s3_ff <= `ANG_SYNC_RST;
            pin_ff <= `ANG_SYNC_RST;
            pin_prev_ff <= `ANG_SYNC_RST;
        end else if (ce_i) begin
            s1_ff <= {sclk_i, ss_n_i, mosi_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
            pin_prev_ff <= pin_ff;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic ss_fell;
    logic ss_act;
    assign sclk_rise = pin_ff[2] & ~pin_prev_ff[2];
    assign sclk_fall = ~pin_ff[2] & pin_prev_ff[2];
    assign ss_fell = ~pin_ff[1] & pin_prev_ff[1];
    assign ss_act = ~pin_ff[1];

    // ---------------------------------------------
    // Serial link: framing
    // ---------------------------------------------
    logic [2:0] bit_cnt_ff;
    logic [1:0] byte_cnt_ff;
    logic [7:0] rx_sr_ff;
    logic [7:0] val_hi_ff;
    logic rw_ff;
    logic skip_ff;
    logic [15:0] tx_sr_ff;
    logic [7:0] rx_next;
    logic byte_done;
    logic [15:0] rd_word;

    assign rx_next = {rx_sr_ff[6:0], pin_ff[0]};
    assign byte_done = ss_act && sclk_rise && bit_cnt_ff == 3'h7;
    assign wr_go = byte_done && byte_cnt_ff == 2'h3 && rw_ff && !store_busy_o;
    assign wr_data = {val_hi_ff, rx_next};

    always_comb begin
        case (addr_ff)
            `ANG_ADR_ANGLE: rd_word = {4'h0, angle_ff};
            `ANG_ADR_SIN: rd_word = {4'h0, sin_ff};
            `ANG_ADR_COS: rd_word = {4'h0, cos_ff};
            `ANG_ADR_DIR: rd_word = {15'h0000, dir_ff};
            `ANG_ADR_ROT: rd_word = {15'h0000, rot_ff};
            `ANG_ADR_OFFSET: rd_word = {2'b00, offset_ff};
            `ANG_ADR_FILTER: rd_word = {8'h00, filt_m_ff};
            `ANG_ADR_HYST: rd_word = {8'h00, hyst_ff};
            `ANG_ADR_LOT0: rd_word = LOT_CODE[47:32];
            `ANG_ADR_LOT1: rd_word = LOT_CODE[31:16];
            `ANG_ADR_LOT2: rd_word = LOT_CODE[15:0];
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 2'h0;
            rx_sr_ff <= 8'h00;
            val_hi_ff <= 8'h00;
            addr_ff <= `ANG_ADR_ANGLE;
            rw_ff <= 1'b0;
            skip_ff <= 1'b0;
            tx_sr_ff <= 16'h0000;
        end else if (ce_i) begin
            if (ss_fell) begin
                bit_cnt_ff <= 3'h0;
                byte_cnt_ff <= 2'h0;
                addr_ff <= `ANG_ADR_ANGLE;
                rw_ff <= 1'b0;
                skip_ff <= 1'b0;
                tx_sr_ff <= {4'h0, angle_ff};
            end else if (ss_act && sclk_rise) begin
                rx_sr_ff <= rx_next;
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == 3'h7) begin
                    // Count wraps every four bytes so angle reads may repeat
                    byte_cnt_ff <= byte_cnt_ff + 2'h1;
                    case (byte_cnt_ff)
                        2'h0: addr_ff <= rx_next;
                        2'h1: begin
                            rw_ff <= rx_next[0];
                            tx_sr_ff <= rx_next[0] ? 16'h0000 : rd_word;
                            skip_ff <= 1'b1;
                        end
                        2'h2: val_hi_ff <= rx_next;
                        default: begin
                        end
                    endcase
                end
            end else if (ss_act && sclk_fall) begin
                // A freshly loaded word keeps its first bit for the next rise
                if (skip_ff) begin
                    skip_ff <= 1'b0;
                end else begin
                    tx_sr_ff <= {tx_sr_ff[14:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else if (ce_i) begin
            miso_o <= tx_sr_ff[15];
            miso_oe_o <= ss_act;
        end
    end

    AST_SS_RESET: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        ss_fell |=> bit_cnt_ff == 3'h0 && byte_cnt_ff == 2'h0 &&
        tx_sr_ff == {4'h0, $past(angle_ff)})
        else $error("select fall did not reset the interface");
    AST_OFFSET_UPPER: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        (byte_done && byte_cnt_ff == 2'h1 && !rx_next[0] && addr_ff == `ANG_ADR_OFFSET)
        |=> tx_sr_ff[15:14] == 2'b00 && tx_sr_ff[13:0] == offset_ff)
        else $error("offset read returned wrong word");
    AST_FILTER_REJECT: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        (wr_go && addr_ff == `ANG_ADR_FILTER && wr_data == 16'h0000)
        |=> filt_m_ff == $past(filt_m_ff))
        else $error("out-of-range filter weight was stored");
    AST_OE: assert property (@(posedge clk_i) disable iff (reset_i || !ce_i)
        ss_act [*2] |=> miso_oe_o ##0 miso_o == $past(tx_sr_ff[15]))
        else $error("output not driven while selected");

endmodule // ang_core

// File: hdl/ang_cfg.svh
// Angle readout constants: timing, link addresses, parameter defaults, angle scales
`ifndef ANG_CFG_SVH
`define ANG_CFG_SVH
// Timing
`define ANG_CLK_HZ 200000000
`define ANG_SAMPLE_HZ 12500
`define ANG_SAMPLE_CYC (`ANG_CLK_HZ / `ANG_SAMPLE_HZ)
`define ANG_STORE_WAIT_TIME_MS 20
`define ANG_STORE_CYC (`ANG_STORE_WAIT_TIME_MS * (`ANG_CLK_HZ / 1000))
`define ANG_ADDRESS_GAP_TIME_US 3
`define ANG_RESPONSE_WAIT_TIME_US 10
// Link addresses
`define ANG_ADR_ANGLE 8'h00
`define ANG_ADR_SIN 8'h01
`define ANG_ADR_COS 8'h02
`define ANG_ADR_DIR 8'h03
`define ANG_ADR_ROT 8'h40
`define ANG_ADR_OFFSET 8'h41
`define ANG_ADR_FILTER 8'h42
`define ANG_ADR_HYST 8'h43
`define ANG_ADR_LOT0 8'h80
`define ANG_ADR_LOT1 8'h81
`define ANG_ADR_LOT2 8'h82
// Parameter defaults and field limits
`define ANG_ROT_RST 1'b0
`define ANG_OFFSET_RST 14'h0000
`define ANG_OFFSET_MSB 13
`define ANG_FILTER_RST 8'h01
`define ANG_HYST_RST 8'h19
// Angle scales: tenths of a degree, fine units are sixteenths of a tenth
`define ANG_FULL_TENTHS 14'sh0E10
`define ANG_HALF_TENTHS 14'sh0708
`define ANG_FULL_FINE 18'sh0E100
`define ANG_HALF_FINE 18'sh07080
`define ANG_FINE_ROUND 18'sh00008
`define ANG_FINE_SHIFT 4
`define ANG_ADC_MID 15'sh0800
`define ANG_ITER_LAST 4'hB
// Synchroniser reset: {sclk, ss_n, mosi}
`define ANG_SYNC_RST 3'h2
`endif

// File: hdl/ang_pkg.sv
// Angle readout types
package ang_pkg;
    typedef enum logic [1:0] {
        ANG_IDLE = 2'b00,
        ANG_ROT = 2'b01,
        ANG_MAP = 2'b11,
        ANG_FILT = 2'b10
    } ang_state_t;
endpackage

// File: verification/ang_spi_master.sv
// Mode 0 link master model for the angle core
`timescale 1ns/1ps
module ang_spi_master #(
    parameter int GAP_ADR = 600,
    parameter int GAP_RSP = 2000
) (
    // Clock
    input wire logic clk_i,
    // Link
    output logic sclk_o,
    output logic ss_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    initial begin
        sclk_o = 1'b0;
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Eight clocks a half period gives the 80 ns link clock
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o <= tx[i];
            repeat (8) @(posedge clk_i);
            sclk_o <= 1'b1;
            rx[i] = miso_i;
            repeat (8) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
    endtask
    task automatic access(input logic [7:0] adr, input logic wr, input logic [15:0] wv,
                          input bit full, output logic [15:0] rv);
        logic [7:0] hi, lo, junk;
        rv = 16'h0000;
        ss_n_o <= 1'b0;
        repeat (16) @(posedge clk_i);
        xbyte(adr, junk);
        if (full) begin
            repeat (GAP_ADR) @(posedge clk_i);
            xbyte({7'h00, wr}, junk);
            repeat (GAP_RSP) @(posedge clk_i);
            xbyte(wv[15:8], hi);
            xbyte(wv[7:0], lo);
            rv = {hi, lo};
        end
        repeat (8) @(posedge clk_i);
        ss_n_o <= 1'b1;
        repeat (16) @(posedge clk_i);
    endtask
endmodule // ang_spi_master

// File: verification/test_ang_core.sv
// Self-checking bench for the angle core
`timescale 1ns/1ps
module test_ang_core;
    localparam int SC = 40;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce = 1'b1;
    logic [11:0] sin_v = 12'h990;
    logic [11:0] cos_v = 12'h990;
    logic sclk, ss_n, mosi, miso_w, miso, miso_oe, start, dir, busy;
    logic [11:0] ang;
    logic [15:0] rv;
    logic [7:0] pa [5] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h7F};
    logic [15:0] pv [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0019, 16'h0000};
    logic [11:0] sv [4] = '{12'h990, 12'h990, 12'h670, 12'h670};
    logic [11:0] cv [4] = '{12'h990, 12'h670, 12'h670, 12'h990};
    logic [15:0] ev [4] = '{16'h01C2, 16'h0546, 16'h08CA, 16'h0C4E};
    int n_errors = 0;
    int checked = 0;
    always #2.5 clk_i = ~clk_i;
    // A released line toggles so a stale bit cannot pass
    assign miso_w = miso_oe ? miso : ~clk_i;
    ang_core #(.SAMPLE_CYC(SC), .STORE_CYC(50)) ang_core_inst (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
        .adc_sin_i(sin_v), .adc_cos_i(cos_v), .adc_start_o(start),
        .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
        .angle_o(ang), .dir_flag_o(dir), .store_busy_o(busy));
    ang_spi_master ang_spi_master_inst (
        .clk_i(clk_i), .sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso_w));
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
        checked++;
        if ($isunknown(got) || (got > exp ? got - exp : exp - got) > tol) begin
            n_errors++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        ang_spi_master_inst.access(a, 1'b0, 16'h0000, 1'b1, rv);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        ang_spi_master_inst.access(a, 1'b1, v, 1'b1, rv);
        chk(rv, 16'h0000, 0);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk_i);
        chk({15'h0, busy}, 16'h0000, 0);
        if (busy !== 1'b0) finish_test();
    endtask
    task automatic vec(input logic [11:0] s, input logic [11:0] c);
        sin_v <= s;
        cos_v <= c;
        repeat (3 * SC) @(posedge clk_i);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3 * SC) @(posedge clk_i);
        ang_spi_master_inst.access(8'h43, 1'b0, 16'h0000, 1'b0, rv);
        foreach (pa[i]) begin
            rd(pa[i]);
            chk(rv, pv[i], 0);
        end
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            vec(sv[i], cv[i]);
            rd(8'h00);
            chk(rv, ev[i], 2);
            chk({4'h0, ang}, ev[i], 2);
            if (i > 0) chk({15'h0, dir}, 16'h0001, 0);
        end
        rd(8'h01);
        chk(rv, 16'h0670, 0);
        rd(8'h02);
        chk(rv, 16'h0990, 0);
        vec(12'h670, 12'h670);
        chk({15'h0, dir}, 16'h0000, 0);
        $display("test angle done");
        wr(8'h42, 16'h0002);
        wr(8'h42, 16'h0000);
        rd(8'h42);
        chk(rv, 16'h0002, 0);
        for (int i = 0; i < 2 * SC && start !== 1'b1; i++) @(posedge clk_i);
        chk({15'h0, start}, 16'h0001, 0);
        if (start !== 1'b1) finish_test();
        sin_v <= 12'h670;
        cos_v <= 12'h990;
        repeat (SC + 20) @(posedge clk_i);
        chk({4'h0, ang}, 16'h0A8C, 2);
        $display("test filter done");
        wr(8'h42, 16'h0001);
        wr(8'h41, 16'h012C);
        wr(8'h41, 16'h0E11);
        rd(8'h41);
        chk(rv, 16'h012C, 0);
        vec(12'h990, 12'h990);
        chk({4'h0, ang}, 16'h0096, 2);
        wr(8'h40, 16'h0001);
        repeat (3 * SC) @(posedge clk_i);
        chk({4'h0, ang}, 16'h0B22, 2);
        wr(8'h00, 16'h0123);
        rd(8'h00);
        chk(rv, 16'h0B22, 2);
        // Enable low must freeze the sampler: the angle may not follow the new vector
        ce <= 1'b0;
        vec(12'h670, 12'h990);
        chk({4'h0, ang}, 16'h0B22, 2);
        ce <= 1'b1;
        vec(12'h670, 12'h990);
        chk({4'h0, ang}, 16'h0096, 2);
        $display("test settings done");
        finish_test();
    end
endmodule // test_ang_core
